// [src/cc_pkg.sv]
// Purpose: constants shared by the dual capture/compare array block
// Assumes: apb byte addresses, one 32-bit word per register
// Notes: channel and timer registers are laid out with fixed strides
// Contract
// - up to 32 channels; resolution one cycle, or eight when staggered
// - each array owns two 16-bit timers, each with its own reload register
// - timer clock selects prescaled system clock or auxiliary timer overflow
// - first timer of each array may also count an external input
// - 16 registers per array, each picks timer and capture or compare
// - twelve second-array registers each own one capture/compare pin
// - capture copies the assigned timer value on the chosen pin edge
// - every capture raises that register's own interrupt request
// - capture edge selectable: rising, falling or both
// - compare registers match continuously against their timer, then act by mode
// - mode 0: interrupt only, many per timer period
// - mode 1: pin toggles on each match, many per period
// - mode 2: interrupt only, at most one per timer period
// - mode 3: match sets pin, timer overflow clears it, one per period
// - double register: two registers toggle one shared pin
// - single-event option gives only one edge or pulse, any compare mode
package cc_pkg;
    localparam logic [11:0] OFS_CC_VALUE = 12'h000;
    localparam logic [11:0] OFS_CC_CTRL = 12'h080;
    localparam logic [11:0] OFS_TIMER = 12'h100;
    localparam logic [11:0] OFS_INT_STATUS = 12'h140;
    localparam logic [11:0] OFS_INT_MASK = 12'h144;
    localparam logic [11:0] OFS_PIN_STATE = 12'h148;
    localparam logic [11:0] OFS_GLOBAL = 12'h14c;
    localparam logic [11:0] CH_AREA_MASK = 12'hf80;
    localparam logic [11:0] TMR_AREA_MASK = 12'hfc0;
    localparam logic [1:0] TMR_F_COUNT = 2'h0;
    localparam logic [1:0] TMR_F_RELOAD = 2'h1;
    localparam logic [1:0] TMR_F_CTRL = 2'h2;
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_TSEL = 3;
    localparam int CTL_EDGE_LSB = 4;
    localparam int CTL_DOUBLE = 6;
    localparam int CTL_SINGLE = 7;
    localparam int TCTL_CLK_LSB = 0;
    localparam int TCTL_RUN = 3;
    localparam int GLB_STAGGER = 0;
    localparam int PIN_IN_LSB = 16;
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_CAPTURE = 3'h1;
    localparam logic [2:0] MODE_CMP0 = 3'h4;
    localparam logic [2:0] MODE_CMP1 = 3'h5;
    localparam logic [2:0] MODE_CMP2 = 3'h6;
    localparam logic [2:0] MODE_CMP3 = 3'h7;
    localparam logic [2:0] CLK_AUX = 3'h6;
    localparam logic [2:0] CLK_EXT = 3'h7;
    localparam logic [2:0] STAGGER_SLOT = 3'h7;
    localparam logic [7:0] RST_CTL = 8'h00;
    localparam logic [3:0] RST_TCTL = 4'h0;
    localparam logic [15:0] RST_RELOAD = 16'h0000;
    localparam logic [15:0] RST_COUNT = 16'h0000;
endpackage

// [src/dual_array_capture_compare.sv]
// Purpose: two capture/compare arrays with two reloadable timers each
// Assumes: pins and count inputs synchronous to pclk; apb slave, one wait state
// Notes: array 1 is channels 0..15 (timers 0,1), array 2 channels 16..31 (timers 2,3)
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module dual_array_capture_compare #(
    parameter int ARRAY_CH = 16,
    parameter int NPINS = 12,
    parameter int TW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic [NPINS-1:0] cc_pin_out,
    output logic [NPINS-1:0] cc_pin_oe,
    input wire logic [NPINS-1:0] cc_pin_in,
    input wire logic [1:0] ext_count_in,
    input wire logic aux_ovf_in
);
    localparam int NCH = 2 * ARRAY_CH;
    localparam int NTMR = 4;
    localparam logic [TW-1:0] TMR_MAX = '1;

    // register state
    logic [TW-1:0] ccval_ff [NCH];
    logic [7:0] ccctl_ff [NCH];
    logic [TW-1:0] tcnt_ff [NTMR];
    logic [TW-1:0] trel_ff [NTMR];
    logic [3:0] tctl_ff [NTMR];
    logic [NCH-1:0] status_ff;
    logic [NCH-1:0] mask_ff;
    logic stagger_ff;
    logic [7:0] pre_ff;
    logic [NTMR-1:0] tupd_ff;
    logic [1:0] ext_prev_ff;
    logic [NCH-1:0] fired_ff;
    logic [NCH-1:0] done_ff;
    logic [NPINS-1:0] pin_prev_ff;
    logic [NPINS-1:0] pin_out_ff;
    logic [NPINS-1:0] pin_oe_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic irq_ff;

    // apb decode
    wire acc = psel & penable;
    wire wr_en = acc & pready_ff & pwrite;
    wire [4:0] idx = paddr[6:2];
    wire [1:0] tidx = paddr[5:4];
    wire [1:0] tfld = paddr[3:2];
    wire aligned = paddr[1:0] == 2'h0;
    wire idx_ok = 32'(idx) < NCH;
    wire hit_val = aligned & idx_ok & ((paddr & cc_pkg::CH_AREA_MASK) == cc_pkg::OFS_CC_VALUE);
    wire hit_ctl = aligned & idx_ok & ((paddr & cc_pkg::CH_AREA_MASK) == cc_pkg::OFS_CC_CTRL);
    wire hit_tmr = aligned & ((paddr & cc_pkg::TMR_AREA_MASK) == cc_pkg::OFS_TIMER)
                   & (tfld != 2'h3);
    wire hit_st = paddr == cc_pkg::OFS_INT_STATUS;
    wire hit_mk = paddr == cc_pkg::OFS_INT_MASK;
    wire hit_pin = paddr == cc_pkg::OFS_PIN_STATE;
    wire hit_glb = paddr == cc_pkg::OFS_GLOBAL;
    wire mapped = hit_val | hit_ctl | hit_tmr | hit_st | hit_mk | hit_pin | hit_glb;
    wire [31:0] pin_word = 32'(pin_out_ff) | (32'(cc_pin_in) << cc_pkg::PIN_IN_LSB);
    wire [31:0] tmr_word = (tfld == cc_pkg::TMR_F_COUNT) ? 32'(tcnt_ff[tidx]) :
                           (tfld == cc_pkg::TMR_F_RELOAD) ? 32'(trel_ff[tidx]) :
                           32'(tctl_ff[tidx]);
    wire [31:0] rdata = hit_val ? 32'(ccval_ff[idx]) :
                        hit_ctl ? 32'(ccctl_ff[idx]) :
                        hit_tmr ? tmr_word :
                        hit_st ? 32'(status_ff) :
                        hit_mk ? 32'(mask_ff) :
                        hit_pin ? pin_word :
                        hit_glb ? 32'(stagger_ff) : 32'h0000_0000;

    // timers
    logic [NTMR-1:0] tick;
    logic [NTMR-1:0] ovf;
    logic [NTMR-1:0] wr_cnt;
    wire slot_ok = ~stagger_ff | (pre_ff[2:0] == cc_pkg::STAGGER_SLOT);

    genvar t;
    generate
        for (t = 0; t < NTMR; t++) begin : g_tmr
            wire [2:0] csel = tctl_ff[t][cc_pkg::TCTL_CLK_LSB +: 3];
            wire [7:0] pmask = ~(8'hff << csel);
            wire pre_hit = (pre_ff & pmask) == pmask;
            wire ext_ev;
            if (t % 2 == 0) begin : g_ext
                // external count: rising edges of the array's count input
                assign ext_ev = ext_count_in[t/2] & ~ext_prev_ff[t/2];
            end else begin : g_noext
                assign ext_ev = 1'b0;
            end
            wire src = (csel == cc_pkg::CLK_AUX) ? aux_ovf_in :
                       (csel == cc_pkg::CLK_EXT) ? ext_ev : pre_hit;
            assign tick[t] = tctl_ff[t][cc_pkg::TCTL_RUN] & src & slot_ok;
            assign ovf[t] = tick[t] & (tcnt_ff[t] == TMR_MAX);
            assign wr_cnt[t] = wr_en & hit_tmr & (tidx == 2'(t))
                               & (tfld == cc_pkg::TMR_F_COUNT);
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NTMR; i++) begin
                tcnt_ff[i] <= cc_pkg::RST_COUNT;
                trel_ff[i] <= cc_pkg::RST_RELOAD;
                tctl_ff[i] <= cc_pkg::RST_TCTL;
            end
            tupd_ff <= '0;
        end else begin
            for (int i = 0; i < NTMR; i++) begin
                if (wr_cnt[i]) begin
                    tcnt_ff[i] <= pwdata[TW-1:0];
                end else if (ovf[i]) begin
                    tcnt_ff[i] <= trel_ff[i];
                end else if (tick[i]) begin
                    tcnt_ff[i] <= tcnt_ff[i] + 1'b1;
                end
                if (wr_en & hit_tmr & (tidx == 2'(i)) & (tfld == cc_pkg::TMR_F_RELOAD)) begin
                    trel_ff[i] <= pwdata[TW-1:0];
                end
                if (wr_en & hit_tmr & (tidx == 2'(i)) & (tfld == cc_pkg::TMR_F_CTRL)) begin
                    tctl_ff[i] <= pwdata[3:0];
                end
            end
            // a software load is not a count step, so it cannot trigger a match
            tupd_ff <= tick & ~wr_cnt;
        end
    end

    // channels
    logic [NCH-1:0] ev;
    logic [NCH-1:0] cap;
    logic [NCH-1:0] limited;
    logic [NCH-1:0] single;
    logic [NCH-1:0] wr_ctl;
    logic [NCH-1:0] tovf;
    logic [TW-1:0] ch_cnt [NCH];

    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            wire [2:0] mode = ccctl_ff[c][cc_pkg::CTL_MODE_LSB +: 3];
            wire [1:0] edge_sel = ccctl_ff[c][cc_pkg::CTL_EDGE_LSB +: 2];
            wire [1:0] tsel = {c >= ARRAY_CH ? 1'b1 : 1'b0, ccctl_ff[c][cc_pkg::CTL_TSEL]};
            wire match = mode[2] & tupd_ff[tsel] & (tcnt_ff[tsel] == ccval_ff[c]);
            assign ch_cnt[c] = tcnt_ff[tsel];
            assign tovf[c] = ovf[tsel];
            assign limited[c] = (mode == cc_pkg::MODE_CMP2) | (mode == cc_pkg::MODE_CMP3);
            assign single[c] = ccctl_ff[c][cc_pkg::CTL_SINGLE];
            assign ev[c] = match & ~done_ff[c] & ~(limited[c] & fired_ff[c]);
            assign wr_ctl[c] = wr_en & hit_ctl & (32'(idx) == c);
            if (c >= ARRAY_CH && c - ARRAY_CH < NPINS) begin : g_cap
                wire rise = cc_pin_in[c-ARRAY_CH] & ~pin_prev_ff[c-ARRAY_CH];
                wire fall = ~cc_pin_in[c-ARRAY_CH] & pin_prev_ff[c-ARRAY_CH];
                assign cap[c] = (mode == cc_pkg::MODE_CAPTURE)
                                & ((edge_sel[0] & rise) | (edge_sel[1] & fall));
            end else begin : g_nocap
                // no pin on this register, so capture never fires
                assign cap[c] = 1'b0;
            end
        end
    endgenerate

    // per-period lock clears on the owning timer's overflow; a new event wins
    wire [NCH-1:0] nxt_fired = (ev & limited) | (fired_ff & ~tovf & ~wr_ctl);
    // single-event lock holds until software rewrites the channel control
    wire [NCH-1:0] nxt_done = (ev & single) | (done_ff & ~wr_ctl);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NCH; i++) begin
                ccval_ff[i] <= cc_pkg::RST_COUNT;
                ccctl_ff[i] <= cc_pkg::RST_CTL;
            end
            fired_ff <= '0;
            done_ff <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (cap[i]) begin
                    ccval_ff[i] <= ch_cnt[i];
                end else if (wr_en & hit_val & (32'(idx) == i)) begin
                    ccval_ff[i] <= pwdata[TW-1:0];
                end
                if (wr_ctl[i]) begin
                    ccctl_ff[i] <= pwdata[7:0];
                end
            end
            fired_ff <= nxt_fired;
            done_ff <= nxt_done;
        end
    end

    // pins of the second array
    logic [NPINS-1:0] nxt_pin;
    logic [NPINS-1:0] nxt_oe;
    genvar p;
    generate
        for (p = 0; p < NPINS; p++) begin : g_pin
            wire [2:0] pmode = ccctl_ff[ARRAY_CH+p][cc_pkg::CTL_MODE_LSB +: 3];
            wire dbl;
            wire pev;
            if (p < ARRAY_CH / 2) begin : g_dbl
                assign dbl = ccctl_ff[ARRAY_CH+p][cc_pkg::CTL_DOUBLE];
                assign pev = ev[ARRAY_CH+p+ARRAY_CH/2];
            end else begin : g_nodbl
                assign dbl = 1'b0;
                assign pev = 1'b0;
            end
            wire m3 = pmode == cc_pkg::MODE_CMP3;
            // both registers matching together toggle twice, leaving the pin as is
            wire tog = (ev[ARRAY_CH+p] & ((pmode == cc_pkg::MODE_CMP1) | dbl))
                       ^ (dbl & pev);
            wire setp = ev[ARRAY_CH+p] & m3;
            wire clrp = m3 & tovf[ARRAY_CH+p];
            assign nxt_pin[p] = setp ? 1'b1 : clrp ? 1'b0 : tog ? ~pin_out_ff[p] : pin_out_ff[p];
            assign nxt_oe[p] = (pmode == cc_pkg::MODE_CMP1) | m3 | dbl;
        end
    endgenerate

    // interrupts: hardware set wins over a same-cycle write-one-to-clear
    wire [NCH-1:0] st_clr = (wr_en & hit_st) ? pwdata[NCH-1:0] : '0;
    wire [NCH-1:0] nxt_status = (status_ff & ~st_clr) | cap | ev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_ff <= '0;
            mask_ff <= '0;
            stagger_ff <= 1'b0;
            irq_ff <= 1'b0;
            pre_ff <= 8'h00;
            ext_prev_ff <= 2'h0;
            pin_prev_ff <= '0;
            pin_out_ff <= '0;
            pin_oe_ff <= '0;
        end else begin
            status_ff <= nxt_status;
            if (wr_en & hit_mk) begin
                mask_ff <= pwdata[NCH-1:0];
            end
            if (wr_en & hit_glb) begin
                stagger_ff <= pwdata[cc_pkg::GLB_STAGGER];
            end
            irq_ff <= |(status_ff & mask_ff);
            pre_ff <= pre_ff + 8'h01;
            ext_prev_ff <= ext_count_in;
            pin_prev_ff <= cc_pin_in;
            pin_out_ff <= nxt_pin;
            pin_oe_ff <= nxt_oe;
        end
    end

    // apb answer: one wait cycle, data and error valid with pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= acc & ~pready_ff;
            pslverr_ff <= acc & ~pready_ff & ~mapped;
            if (acc & ~pready_ff & ~pwrite) begin
                prdata_ff <= rdata;
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
    assign cc_pin_out = pin_out_ff;
    assign cc_pin_oe = pin_oe_ff;

    // checks on the channels, pins and timers that the bench exercises
    wire [2:0] m16 = ccctl_ff[ARRAY_CH][2:0];
    wire [2:0] m17 = ccctl_ff[ARRAY_CH+1][2:0];
    wire [2:0] m18 = ccctl_ff[ARRAY_CH+2][2:0];

    property p_cap_latch;
        @(posedge pclk) disable iff (!presetn)
        cap[ARRAY_CH] |=> ccval_ff[ARRAY_CH] == $past(ch_cnt[ARRAY_CH]);
    endproperty
    a_cap_latch: assert property (p_cap_latch) else $error("capture did not latch timer");

    property p_cap_irq;
        @(posedge pclk) disable iff (!presetn)
        cap[ARRAY_CH] |=> status_ff[ARRAY_CH];
    endproperty
    a_cap_irq: assert property (p_cap_irq) else $error("capture did not set status");

    property p_edge_sel;
        @(posedge pclk) disable iff (!presetn)
        (m16 == cc_pkg::MODE_CAPTURE && cc_pin_in[0] && !pin_prev_ff[0])
            |-> cap[ARRAY_CH] == ccctl_ff[ARRAY_CH][cc_pkg::CTL_EDGE_LSB];
    endproperty
    a_edge_sel: assert property (p_edge_sel) else $error("rising edge selection wrong");

    property p_cmp_irq;
        @(posedge pclk) disable iff (!presetn)
        (ev[0] && ccctl_ff[0][2:0] == cc_pkg::MODE_CMP0) |=> status_ff[0];
    endproperty
    a_cmp_irq: assert property (p_cmp_irq) else $error("compare match lost its interrupt");

    property p_toggle;
        @(posedge pclk) disable iff (!presetn)
        (ev[ARRAY_CH+1] && m17 == cc_pkg::MODE_CMP1 && !ccctl_ff[ARRAY_CH+1][cc_pkg::CTL_DOUBLE])
            |=> cc_pin_out[1] != $past(cc_pin_out[1]);
    endproperty
    a_toggle: assert property (p_toggle) else $error("mode 1 pin did not toggle");

    property p_once;
        @(posedge pclk) disable iff (!presetn)
        (ev[1] && limited[1]) ##1 (!tovf[1] && !wr_ctl[1]) |-> !ev[1] ##1 !ev[1];
    endproperty
    a_once: assert property (p_once) else $error("second event in one timer period");

    property p_mode3_set;
        @(posedge pclk) disable iff (!presetn)
        (ev[ARRAY_CH+2] && m18 == cc_pkg::MODE_CMP3) |=> cc_pin_out[2] && cc_pin_oe[2];
    endproperty
    a_mode3_set: assert property (p_mode3_set) else $error("mode 3 match did not set pin");

    property p_mode3_clr;
        @(posedge pclk) disable iff (!presetn)
        (tovf[ARRAY_CH+2] && !ev[ARRAY_CH+2] && m18 == cc_pkg::MODE_CMP3) |=> !cc_pin_out[2];
    endproperty
    a_mode3_clr: assert property (p_mode3_clr) else $error("mode 3 overflow did not clear pin");

    property p_single;
        @(posedge pclk) disable iff (!presetn)
        (ev[3] && single[3] && !wr_ctl[3]) |=> !ev[3];
    endproperty
    a_single: assert property (p_single) else $error("single event fired again");

    property p_reload;
        @(posedge pclk) disable iff (!presetn)
        (ovf[2] && !wr_cnt[2]) |=> tcnt_ff[2] == $past(trel_ff[2]) && tupd_ff[2];
    endproperty
    a_reload: assert property (p_reload) else $error("timer did not reload");

    property p_count_step;
        @(posedge pclk) disable iff (!presetn)
        (tick[2] && !ovf[2] && !wr_cnt[2]) |=> tcnt_ff[2] == TW'($past(tcnt_ff[2]) + 1'b1);
    endproperty
    a_count_step: assert property (p_count_step) else $error("timer did not step");

    property p_cmp_status;
        @(posedge pclk) disable iff (!presetn)
        ev[1] |=> status_ff[1];
    endproperty
    a_cmp_status: assert property (p_cmp_status) else $error("match lost its status");

    // pin 4 is shared by channels 20 and 28 once double mode is on
    property p_dbl_toggle;
        @(posedge pclk) disable iff (!presetn)
        (ev[ARRAY_CH+ARRAY_CH/2+4] && !ev[ARRAY_CH+4] && ccctl_ff[ARRAY_CH+4][cc_pkg::CTL_DOUBLE]
            && ccctl_ff[ARRAY_CH+4][2:0] != cc_pkg::MODE_CMP3)
            |=> cc_pin_out[4] != $past(cc_pin_out[4]);
    endproperty
    a_dbl_toggle: assert property (p_dbl_toggle) else $error("partner match did not toggle");

    // staggered ticks come at most once in eight cycles
    property p_stagger;
        @(posedge pclk) disable iff (!presetn)
        (stagger_ff && |tick) |=> (!stagger_ff || tick == '0)[*7];
    endproperty
    a_stagger: assert property (p_stagger) else $error("staggered tick came too soon");
endmodule
`default_nettype wire

// [verif/cc_pin_partner.sv]
// Purpose: far-side model of the capture/compare pins
// Assumes: pins are synchronous to pclk
// Notes: pin_line is the wire level seen from outside
`timescale 1ns/10ps
`default_nettype none
module cc_pin_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] want_level,
    input wire logic [11:0] cc_pin_out,
    input wire logic [11:0] cc_pin_oe,
    output logic [11:0] cc_pin_in,
    output logic [11:0] pin_line
);
    logic [1:0] hold_ff;

    // a level stays at least four cycles so the sampler cannot miss it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cc_pin_in <= 12'h000;
            hold_ff <= 2'h0;
        end else if (hold_ff != 2'h0) begin
            hold_ff <= hold_ff - 2'h1;
        end else if (want_level != cc_pin_in) begin
            cc_pin_in <= want_level;
            hold_ff <= 2'h3;
        end
    end

    assign pin_line = (cc_pin_oe & cc_pin_out) | (~cc_pin_oe & cc_pin_in);
endmodule
`default_nettype wire

// [verif/dual_array_capture_compare_tb.sv]
// Purpose: self-checking bench for the dual capture/compare arrays
// Assumes: apb slave answers with pready; timers clocked by ext/aux inputs, timer 3 by pclk in the stagger test
// Notes: external count pulses keep the values of timers 0 and 2 deterministic
`timescale 1ns/10ps
`default_nettype none
module dual_array_capture_compare_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, aux_ovf_in, e;
    logic [11:0] paddr, cc_pin_out, cc_pin_oe, cc_pin_in, want_level, pin_line;
    logic [31:0] pwdata, prdata, q;
    logic [1:0] ext_count_in;
    int err_total, tests_run;

    dual_array_capture_compare DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe), .cc_pin_in(cc_pin_in),
        .ext_count_in(ext_count_in), .aux_ovf_in(aux_ovf_in));
    cc_pin_partner u_far (.pclk(pclk), .presetn(presetn), .want_level(want_level),
        .cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe), .cc_pin_in(cc_pin_in),
        .pin_line(pin_line));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // one apb transfer; waits for pready at a rising edge, bounded
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            $display("[FAIL] %0t apb transfer got no pready", $time);
            err_total++;
            print_verdict();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m,
                      input string msg);
        apb(1'b0, a, 32'h0);
        chk(q & m, exp, msg);
    endtask

    // n rising edges on an external count input, then settle time for events
    task automatic tick(input int i, input int n);
        repeat (n) begin
            ext_count_in[i] <= 1'b1;
            repeat (2) @(posedge pclk);
            ext_count_in[i] <= 1'b0;
            repeat (2) @(posedge pclk);
        end
        repeat (4) @(posedge pclk);
    endtask

    task automatic pin(input int p, input logic lvl);
        want_level[p] <= lvl;
        repeat (10) @(posedge pclk);
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        $display("[FAIL] %0t run did not finish", $time);
        err_total++;
        print_verdict();
    end

    initial begin
        err_total = 0;
        tests_run = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        aux_ovf_in = 1'b0;
        ext_count_in = 2'h0;
        want_level = 12'h000;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(12'h094, 32'h0, 32'hffffffff, "ctrl reset");
        rd(12'h118, 32'h0, 32'hffffffff, "timer ctrl reset");
        rd(12'hffc, 32'h0, 32'hffffffff, "unmapped read");
        chk({31'h0, e}, 32'h1, "unmapped err");
        apb(1'b0, 12'h002, 32'h0);
        chk({31'h0, e}, 32'h1, "unaligned err");
        wr(12'h144, 32'hffffffff);
        // timer b of array 1 on aux overflow; channel 2 picks it
        wr(12'h008, 32'h2);
        wr(12'h088, 32'h0c);
        wr(12'h118, 32'he);
        repeat (2) begin
            aux_ovf_in <= 1'b1;
            @(posedge pclk);
            aux_ovf_in <= 1'b0;
            repeat (3) @(posedge pclk);
        end
        rd(12'h110, 32'h2, 32'hffff, "aux count");
        rd(12'h140, 32'h4, 32'hffffffff, "cmp on timer b");
        chk({31'h0, irq}, 32'h1, "irq up");
        wr(12'h144, 32'h0);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(12'h144, 32'hffffffff);
        wr(12'h140, 32'h4);
        rd(12'h140, 32'h0, 32'hffffffff, "w1c");
        chk({31'h0, irq}, 32'h0, "irq cleared");
        // mode 0 and mode 2 on timer a, external count
        wr(12'h000, 32'h3);
        wr(12'h004, 32'h4);
        wr(12'h080, 32'h04);
        wr(12'h084, 32'h06);
        wr(12'h108, 32'hf);
        tick(0, 3);
        rd(12'h100, 32'h3, 32'hffff, "ext count");
        rd(12'h140, 32'h1, 32'h3, "mode 0 match");
        tick(0, 1);
        rd(12'h140, 32'h3, 32'h3, "mode 2 match");
        wr(12'h140, 32'h3);
        wr(12'h100, 32'h2);
        tick(0, 2);
        rd(12'h140, 32'h1, 32'h3, "mode 0 again, mode 2 once");
        // single event on channel 3, mode 0, timer a of array 1
        wr(12'h00c, 32'h5);
        wr(12'h08c, 32'h84);
        tick(0, 1);
        rd(12'h140, 32'h8, 32'h8, "single first");
        wr(12'h140, 32'h8);
        wr(12'h100, 32'h4);
        tick(0, 1);
        rd(12'h140, 32'h0, 32'h8, "single locked");
        // capture on channel 16, pin 0, timer a of array 2
        wr(12'h128, 32'hf);
        tick(1, 5);
        wr(12'h0c0, 32'h11);
        pin(0, 1'b1);
        rd(12'h040, 32'h5, 32'hffff, "rising capture");
        rd(12'h140, 32'h10000, 32'h10000, "capture irq");
        wr(12'h140, 32'h10000);
        tick(1, 1);
        pin(0, 1'b0);
        rd(12'h040, 32'h5, 32'hffff, "falling ignored");
        wr(12'h0c0, 32'h21);
        tick(1, 1);
        pin(0, 1'b1);
        rd(12'h040, 32'h5, 32'hffff, "rising ignored");
        pin(0, 1'b0);
        rd(12'h040, 32'h7, 32'hffff, "falling capture");
        wr(12'h0c0, 32'h31);
        tick(1, 1);
        pin(0, 1'b1);
        rd(12'h040, 32'h8, 32'hffff, "both edges");
        // mode 1 on pin 1, mode 3 on pin 2
        wr(12'h120, 32'h0);
        wr(12'h044, 32'h2);
        wr(12'h048, 32'h3);
        wr(12'h0c4, 32'h05);
        wr(12'h0c8, 32'h07);
        tick(1, 2);
        rd(12'h148, 32'h2, 32'hfff, "toggle up");
        tick(1, 1);
        rd(12'h148, 32'h6, 32'hfff, "mode 3 set");
        chk({20'h0, cc_pin_oe & 12'h006}, 32'h6, "pins driven");
        chk({20'h0, pin_line & 12'h006}, 32'h6, "wire level");
        wr(12'h124, 32'h1);
        wr(12'h120, 32'hfffe);
        tick(1, 2);
        rd(12'h120, 32'h1, 32'hffff, "reload");
        rd(12'h148, 32'h2, 32'hfff, "overflow clears");
        tick(1, 1);
        rd(12'h148, 32'h0, 32'hfff, "toggle down");
        tick(1, 1);
        rd(12'h148, 32'h4, 32'hfff, "set next period");
        // double mode: channels 20 and 28 share pin 4
        wr(12'h050, 32'h2);
        wr(12'h070, 32'h3);
        wr(12'h0d0, 32'h44);
        wr(12'h0f0, 32'h04);
        wr(12'h120, 32'h0);
        tick(1, 2);
        rd(12'h148, 32'h10, 32'h10, "double first toggle");
        tick(1, 1);
        rd(12'h148, 32'h0, 32'h10, "double second toggle");
        // stagger: 64 run cycles of timer 3 on pclk give eight ticks
        wr(12'h14c, 32'h1);
        wr(12'h138, 32'h8);
        repeat (60) @(posedge pclk);
        wr(12'h138, 32'h0);
        rd(12'h130, 32'h8, 32'hffff, "stagger ticks");
        print_verdict();
    end
endmodule
`default_nettype wire
